//--- rtl/accel_pkg.sv
// Purpose: Shared constants and types for the accelerometer control core.
// Assumes: 50 MHz core clock; register index times four gives the APB byte address.
// Notes: Indices not multiples of four, so every offset is kept as an index.
package accel_pkg;

	localparam int clk_hz = 50_000_000;
	localparam int clk_period_ns = 20;

	// Register indices; byte address is four times the index.
	localparam logic [7:0] dev_status_idx = 8'h05;
	localparam logic [7:0] int_enable_idx = 8'h06;
	localparam logic [7:0] mode_idx = 8'h07;
	localparam logic [7:0] sample_rate_idx = 8'h08;
	localparam logic [7:0] x_lo_idx = 8'h0D;
	localparam logic [7:0] x_hi_idx = 8'h0E;
	localparam logic [7:0] y_lo_idx = 8'h0F;
	localparam logic [7:0] y_hi_idx = 8'h10;
	localparam logic [7:0] z_lo_idx = 8'h11;
	localparam logic [7:0] z_hi_idx = 8'h12;
	localparam logic [7:0] int_status_idx = 8'h14;
	localparam logic [7:0] soft_reset_idx = 8'h1F;
	localparam logic [7:0] range_idx = 8'h20;

	// Field positions.
	localparam int state_lsb = 0;
	localparam int unlock_bit = 3;
	localparam int drive_bit = 6;
	localparam int polarity_bit = 7;
	localparam int sample_ready_bit = 7;
	localparam int reset_req_bit = 0;

	// Reset values.
	localparam logic [7:0] mode_rst = 8'h00;
	localparam logic [7:0] int_enable_rst = 8'h00;
	localparam logic [2:0] rate_rst = 3'h0;
	localparam logic [2:0] range_rst = 3'h0;

	// State field codes.
	localparam logic [1:0] code_standby = 2'h0;
	localparam logic [1:0] code_wake = 2'h1;

	// Timing.
	localparam int wake_time_ns = 10_000;
	localparam int wake_cycles = wake_time_ns / clk_period_ns;
	localparam int slowest_rate_sps = 31;
	localparam int slowest_period_cycles = clk_hz / slowest_rate_sps;
	localparam int rate_code_max = 5;

	typedef enum logic {standby, wake} op_state_e;

	typedef struct packed {
		logic signed [17:0] x;
		logic signed [17:0] y;
		logic signed [17:0] z;
	} axis_raw_s;

	typedef struct packed {
		logic [15:0] x;
		logic [15:0] y;
		logic [15:0] z;
	} axis_sample_s;

endpackage

//--- rtl/sample_timer.sv
// Purpose: Sample clock divider producing one tick per output sample.
// Assumes: Rate code n selects the slowest period shifted right by n, with n clamped to 5.
// Notes: Counter is held at zero when not running, so no tick after the first standby cycle.
`timescale 1ns/1ps
module sample_timer
#(
	parameter int slowest_period = accel_pkg::slowest_period_cycles
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic run,
	input wire logic [2:0] rate_code,
	output logic tick
);
	localparam int cnt_w = $clog2(slowest_period + 1);
	localparam logic [2:0] code_max = 3'(accel_pkg::rate_code_max);

	logic [cnt_w-1:0] count_ff;
	logic [cnt_w-1:0] nxt_count;
	logic [cnt_w-1:0] period;
	logic tick_ff;
	logic nxt_tick;

	generate
		if (slowest_period < 64)
		begin : g_check
			$error("sample_timer: slowest_period too small for all rate codes");
		end
	endgenerate

	// Codes above the fastest rate clamp to it.
	function automatic logic [cnt_w-1:0] period_of(input logic [2:0] code);
		logic [2:0] sh;
		sh = (code > code_max) ? code_max : code;
		return cnt_w'(slowest_period >> sh);
	endfunction

	always_comb
	begin
		period = period_of(rate_code);
		nxt_tick = 1'b0;
		nxt_count = count_ff;
		if (!run)
			nxt_count = '0;
		else if (count_ff >= period - cnt_w'(1))
		begin
			nxt_count = '0;
			nxt_tick = 1'b1;
		end
		else
			nxt_count = count_ff + cnt_w'(1);
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			count_ff <= '0;
			tick_ff <= 1'b0;
		end
		else
		begin
			count_ff <= nxt_count;
			tick_ff <= nxt_tick;
		end
	end

	assign tick = tick_ff;

endmodule // sample_timer

//--- rtl/accel_core.sv
// Purpose: Control core of a three-axis accelerometer behind an APB slave.
// Assumes: Two-wire bus pins observed only to find START and STOP conditions.
// Notes: Sample and flag updates wait for a STOP and an idle two-wire bus.
//
// Behaviour
// - Power-up enters standby and stays there.
// - State changes only by software command.
// - Standby to wake within one sample period.
// - Soft reset accepted only while in wake.
// - Standby stops sample clock and sampling.
// - Standby accepts writes to every register.
// - Wake ignores writes except mode and soft reset registers.
// - Unlock bit permits all writes in wake.
// - Status register reports the current state.
// - State code 00 selects standby.
// - State code 01 selects wake, continuous sampling.
// - Wake samples three axes at selected rate.
// - Range field selects span 2 to 16 g.
// - Axis results are saturated 16-bit signed.
// - Wake refreshes the sample holding set every period.
// - New sample moves only after a STOP.
// - Enable register gates events onto interrupt.
// - Status read in wake clears flags and interrupt.
// - Sample-ready flag set once per sample.
// - Interrupt only when sample-ready enable set.
// - Pin polarity and drive follow mode bits.
// - Standby leaves pending flags uncleared.
// - Interrupt status register at index 14h.
// - Updates deferred while bus transaction runs.
`timescale 1ns/1ps
module accel_core
#(
	parameter int slowest_period = accel_pkg::slowest_period_cycles
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire accel_pkg::axis_raw_s raw_sample,
	output logic sample_strobe,
	output logic [2:0] range_select,
	output logic irq_out_n,
	output logic irq_oe_n
);
	localparam int wake_bound = accel_pkg::wake_cycles;

	logic [2:0] scl_sync_ff;
	logic [2:0] sda_sync_ff;
	logic scl_ff;
	logic sda_ff;
	logic nxt_scl;
	logic nxt_sda;
	logic start_evt;
	logic stop_evt;

	accel_pkg::op_state_e op_state_ff;
	accel_pkg::op_state_e nxt_op_state;
	logic [7:0] mode_ff;
	logic [7:0] nxt_mode;
	logic [7:0] int_enable_ff;
	logic [7:0] nxt_int_enable;
	logic [2:0] rate_ff;
	logic [2:0] nxt_rate;
	logic [2:0] range_ff;
	logic [2:0] nxt_range;

	accel_pkg::axis_sample_s held_ff;
	accel_pkg::axis_sample_s nxt_held;
	accel_pkg::axis_sample_s samples_ff;
	accel_pkg::axis_sample_s nxt_samples;
	logic held_valid_ff;
	logic nxt_held_valid;
	logic stop_seen_ff;
	logic nxt_stop_seen;
	logic busy_ff;
	logic nxt_busy;
	logic flag_ff;
	logic nxt_flag;
	logic irq_level_ff;
	logic nxt_irq_level;
	logic irq_oe_n_ff;
	logic nxt_irq_oe_n;

	logic pready_ff;
	logic nxt_pready;
	logic [31:0] prdata_ff;
	logic [31:0] nxt_prdata;
	logic pslverr_ff;
	logic nxt_pslverr;

	logic tick;
	logic [7:0] idx;
	logic done;
	logic wr_done;
	logic wr_ok;
	logic soft_reset;
	logic apply;
	logic status_clear;
	logic irq_active;

	function automatic logic [15:0] saturate(input logic signed [17:0] v);
		if (v > 18'sh0_7FFF)
			return 16'h7FFF;
		else if (v < -18'sh0_8000)
			return 16'h8000;
		else
			return v[15:0];
	endfunction

	function automatic logic mapped(input logic [7:0] i);
		case (i)
			accel_pkg::dev_status_idx, accel_pkg::int_enable_idx, accel_pkg::mode_idx,
			accel_pkg::sample_rate_idx, accel_pkg::x_lo_idx, accel_pkg::x_hi_idx,
			accel_pkg::y_lo_idx, accel_pkg::y_hi_idx, accel_pkg::z_lo_idx,
			accel_pkg::z_hi_idx, accel_pkg::int_status_idx, accel_pkg::soft_reset_idx,
			accel_pkg::range_idx: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	sample_timer #(
		.slowest_period(slowest_period)
	) i_sample_timer (
		.clk(clk),
		.reset(reset),
		.run(op_state_ff == accel_pkg::wake),
		.rate_code(rate_ff),
		.tick(tick)
	);

	// Only the agreeing second and third stages are looked at.
	always_comb
	begin
		nxt_scl = (scl_sync_ff[1] == scl_sync_ff[2]) ? scl_sync_ff[2] : scl_ff;
		nxt_sda = (sda_sync_ff[1] == sda_sync_ff[2]) ? sda_sync_ff[2] : sda_ff;
		start_evt = scl_ff && nxt_scl && sda_ff && !nxt_sda;
		stop_evt = scl_ff && nxt_scl && !sda_ff && nxt_sda;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			scl_sync_ff <= 3'h7;
			sda_sync_ff <= 3'h7;
			scl_ff <= 1'b1;
			sda_ff <= 1'b1;
		end
		else
		begin
			scl_sync_ff <= {scl_sync_ff[1:0], scl_in};
			sda_sync_ff <= {sda_sync_ff[1:0], sda_in};
			scl_ff <= nxt_scl;
			sda_ff <= nxt_sda;
		end
	end

	assign idx = paddr[9:2];
	assign done = psel && penable && pready_ff;
	assign wr_done = done && pwrite && mapped(idx) && paddr[1:0] == 2'h0;
	assign wr_ok = op_state_ff == accel_pkg::standby
		|| idx == accel_pkg::mode_idx || idx == accel_pkg::soft_reset_idx
		|| mode_ff[accel_pkg::unlock_bit];
	assign soft_reset = wr_done && idx == accel_pkg::soft_reset_idx
		&& pwdata[accel_pkg::reset_req_bit] && op_state_ff == accel_pkg::wake;

	// Configuration and operating state.
	always_comb
	begin
		nxt_op_state = op_state_ff;
		nxt_mode = mode_ff;
		nxt_int_enable = int_enable_ff;
		nxt_rate = rate_ff;
		nxt_range = range_ff;
		if (soft_reset)
		begin
			nxt_op_state = accel_pkg::standby;
			nxt_mode = accel_pkg::mode_rst;
			nxt_int_enable = accel_pkg::int_enable_rst;
			nxt_rate = accel_pkg::rate_rst;
			nxt_range = accel_pkg::range_rst;
		end
		else if (wr_done && wr_ok)
		begin
			case (idx)
				accel_pkg::mode_idx:
				begin
					nxt_mode = pwdata[7:0];
					// Codes 10 and 11 leave the state as it is.
					case (pwdata[accel_pkg::state_lsb +: 2])
						accel_pkg::code_standby: nxt_op_state = accel_pkg::standby;
						accel_pkg::code_wake: nxt_op_state = accel_pkg::wake;
						default: nxt_op_state = op_state_ff;
					endcase
				end
				accel_pkg::int_enable_idx: nxt_int_enable = pwdata[7:0];
				accel_pkg::sample_rate_idx: nxt_rate = pwdata[2:0];
				accel_pkg::range_idx: nxt_range = pwdata[2:0];
				default: nxt_mode = mode_ff;
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			op_state_ff <= accel_pkg::standby;
			mode_ff <= accel_pkg::mode_rst;
			int_enable_ff <= accel_pkg::int_enable_rst;
			rate_ff <= accel_pkg::rate_rst;
			range_ff <= accel_pkg::range_rst;
		end
		else
		begin
			op_state_ff <= nxt_op_state;
			mode_ff <= nxt_mode;
			int_enable_ff <= nxt_int_enable;
			rate_ff <= nxt_rate;
			range_ff <= nxt_range;
		end
	end

	assign range_select = range_ff;
	assign sample_strobe = tick;

	// Samples are parked in a holding set until the two-wire bus allows the move.
	assign apply = held_valid_ff && stop_seen_ff && !busy_ff && !start_evt;
	assign status_clear = done && !pwrite && idx == accel_pkg::int_status_idx
		&& op_state_ff == accel_pkg::wake;

	always_comb
	begin
		nxt_held = held_ff;
		nxt_held_valid = held_valid_ff;
		nxt_samples = samples_ff;
		nxt_stop_seen = stop_seen_ff || stop_evt;
		nxt_busy = (busy_ff || start_evt) && !stop_evt;
		if (apply)
		begin
			nxt_samples = held_ff;
			nxt_held_valid = 1'b0;
			nxt_stop_seen = stop_evt;
		end
		if (tick)
		begin
			nxt_held.x = saturate(raw_sample.x);
			nxt_held.y = saturate(raw_sample.y);
			nxt_held.z = saturate(raw_sample.z);
			nxt_held_valid = 1'b1;
		end
		if (soft_reset)
		begin
			nxt_held_valid = 1'b0;
			nxt_samples = '0;
		end
		// Set wins over a simultaneous clear so no sample is lost.
		nxt_flag = apply || (flag_ff && !status_clear && !soft_reset);
		irq_active = flag_ff && int_enable_ff[accel_pkg::sample_ready_bit];
		nxt_irq_level = mode_ff[accel_pkg::polarity_bit] ? irq_active : !irq_active;
		if (mode_ff[accel_pkg::drive_bit])
		begin
			nxt_irq_oe_n = 1'b0;
		end
		else
		begin
			nxt_irq_oe_n = nxt_irq_level;
			nxt_irq_level = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			held_ff <= '0;
			held_valid_ff <= 1'b0;
			samples_ff <= '0;
			stop_seen_ff <= 1'b1;
			busy_ff <= 1'b0;
			flag_ff <= 1'b0;
			irq_level_ff <= 1'b0;
			irq_oe_n_ff <= 1'b1;
		end
		else
		begin
			held_ff <= nxt_held;
			held_valid_ff <= nxt_held_valid;
			samples_ff <= nxt_samples;
			stop_seen_ff <= nxt_stop_seen;
			busy_ff <= nxt_busy;
			flag_ff <= nxt_flag;
			irq_level_ff <= nxt_irq_level;
			irq_oe_n_ff <= nxt_irq_oe_n;
		end
	end

	assign irq_out_n = irq_level_ff;
	assign irq_oe_n = irq_oe_n_ff;

	// One wait state lets read data come from a flip-flop.
	always_comb
	begin
		nxt_pready = 1'b0;
		nxt_prdata = prdata_ff;
		nxt_pslverr = 1'b0;
		if (psel && penable && !pready_ff)
		begin
			nxt_pready = 1'b1;
			nxt_pslverr = !mapped(idx) || paddr[1:0] != 2'h0;
			case (idx)
				accel_pkg::dev_status_idx: nxt_prdata = {30'h0000_0000,
					(op_state_ff == accel_pkg::wake) ? accel_pkg::code_wake
					: accel_pkg::code_standby};
				accel_pkg::int_enable_idx: nxt_prdata = {24'h00_0000, int_enable_ff};
				accel_pkg::mode_idx: nxt_prdata = {24'h00_0000, mode_ff};
				accel_pkg::sample_rate_idx: nxt_prdata = {29'h0000_0000, rate_ff};
				accel_pkg::range_idx: nxt_prdata = {29'h0000_0000, range_ff};
				accel_pkg::x_lo_idx: nxt_prdata = {24'h00_0000, samples_ff.x[7:0]};
				accel_pkg::x_hi_idx: nxt_prdata = {24'h00_0000, samples_ff.x[15:8]};
				accel_pkg::y_lo_idx: nxt_prdata = {24'h00_0000, samples_ff.y[7:0]};
				accel_pkg::y_hi_idx: nxt_prdata = {24'h00_0000, samples_ff.y[15:8]};
				accel_pkg::z_lo_idx: nxt_prdata = {24'h00_0000, samples_ff.z[7:0]};
				accel_pkg::z_hi_idx: nxt_prdata = {24'h00_0000, samples_ff.z[15:8]};
				accel_pkg::int_status_idx: nxt_prdata = {24'h00_0000, flag_ff, 7'h00};
				default: nxt_prdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			pready_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
			pslverr_ff <= 1'b0;
		end
		else
		begin
			pready_ff <= nxt_pready;
			prdata_ff <= nxt_prdata;
			pslverr_ff <= nxt_pslverr;
		end
	end

	assign pready = pready_ff;
	assign prdata = prdata_ff;
	assign pslverr = pslverr_ff;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence wake_cmd;
		wr_done && wr_ok && idx == accel_pkg::mode_idx
			&& pwdata[1:0] == accel_pkg::code_wake;
	endsequence

	sequence status_read_now;
		status_clear && !apply;
	endsequence

	standby_holds_a: assert property (
		op_state_ff == accel_pkg::standby && !(wr_done && idx == accel_pkg::mode_idx)
		|=> op_state_ff == accel_pkg::standby)
		else $error("standby left without a mode write");
	wake_holds_a: assert property (
		op_state_ff == accel_pkg::wake && !wr_done |=> op_state_ff == accel_pkg::wake)
		else $error("wake left without software command");
	wake_entry_a: assert property (
		wake_cmd |-> ##[1:wake_bound] op_state_ff == accel_pkg::wake)
		else $error("wake not reached in time");
	reset_refused_a: assert property (
		op_state_ff == accel_pkg::standby && wr_done && idx == accel_pkg::soft_reset_idx
		|=> $stable(int_enable_ff) && $stable(range_ff))
		else $error("soft reset acted in standby");
	no_tick_standby_a: assert property (
		(op_state_ff == accel_pkg::standby) [*2] |-> !tick)
		else $error("sample tick while in standby");
	wake_lock_a: assert property (
		op_state_ff == accel_pkg::wake && !mode_ff[accel_pkg::unlock_bit]
		&& wr_done && idx == accel_pkg::range_idx |=> $stable(range_ff))
		else $error("locked register written in wake");
	unlock_write_a: assert property (
		op_state_ff == accel_pkg::wake && mode_ff[accel_pkg::unlock_bit] && !soft_reset
		&& wr_done && idx == accel_pkg::range_idx |=> range_ff == $past(pwdata[2:0]))
		else $error("unlocked write not taken");
	sample_gate_a: assert property (
		!$stable(samples_ff) && !$past(soft_reset) |-> $past(stop_seen_ff && !busy_ff))
		else $error("sample moved without STOP or while busy");
	flag_set_a: assert property (
		apply |=> flag_ff)
		else $error("sample-ready flag not set");
	status_clear_a: assert property (
		status_read_now |=> !flag_ff
		##1 (($past(mode_ff[accel_pkg::drive_bit]) ? irq_out_n : irq_oe_n)
		== !$past(mode_ff[accel_pkg::polarity_bit])))
		else $error("status read did not clear flag");
	// The pin level is judged as the line shows it, so open drain counts as released high.
	irq_gate_a: assert property (
		!$past(int_enable_ff[accel_pkg::sample_ready_bit])
		|-> ($past(mode_ff[accel_pkg::drive_bit]) ? irq_out_n : irq_oe_n)
		== !$past(mode_ff[accel_pkg::polarity_bit]))
		else $error("interrupt raised while disabled");
	pin_drive_a: assert property (
		mode_ff[accel_pkg::drive_bit] && $past(mode_ff[accel_pkg::drive_bit]) |-> !irq_oe_n)
		else $error("push-pull pin not driven");

endmodule // accel_core

//--- tb/i2c_master_model.sv
// Purpose: Two-wire bus master that frames START and STOP on the link.
// Assumes: Link clock of 160 ns (eight core cycles), still outside frames.
// Notes: Lines rest high as with pull-ups; no data bits are sent.
`timescale 1ns/1ps
module i2c_master_model
(
	input wire logic clk,
	output logic scl,
	output logic sda
);
	initial
	begin
		scl = 1'b1;
		sda = 1'b1;
	end
	task automatic half();
		repeat (4) @(posedge clk);
	endtask
	task automatic start_cond();
		half();
		sda <= 1'b0;
		half();
		scl <= 1'b0;
		half();
		scl <= 1'b1;
		half();
		scl <= 1'b0;
	endtask
	// Every frame is closed, otherwise the core never moves a new sample.
	task automatic stop_cond();
		half();
		sda <= 1'b0;
		half();
		scl <= 1'b1;
		half();
		sda <= 1'b1;
	endtask
	task automatic frame();
		start_cond();
		stop_cond();
	endtask
endmodule // i2c_master_model

//--- tb/tb_accel_state_sampling_irq.sv
// Purpose: Register-level bench for the accelerometer control core.
// Assumes: Slowest period shortened to 640 cycles; rate code 4 gives 40 cycles.
// Notes: The 40-cycle period leaves room to open a frame between two samples.
`timescale 1ns/1ps
module tb_accel_state_sampling_irq;
	localparam int slow = 640;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic scl;
	logic sda;
	accel_pkg::axis_raw_s raw = '0;
	logic sample_strobe;
	logic [2:0] range_select;
	logic irq_out_n;
	logic irq_oe_n;
	logic [31:0] rdata;
	logic rerr;
	int err_count = 0;
	int compares = 0;
	int cycles = 0;
	int n;
	always #10 clk = ~clk;
	i2c_master_model i_i2c_master_model (.clk(clk), .scl(scl), .sda(sda));
	accel_core #(.slowest_period(slow)) i_accel_core (.clk(clk), .reset(reset),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl), .sda_in(sda),
		.raw_sample(raw), .sample_strobe(sample_strobe), .range_select(range_select),
		.irq_out_n(irq_out_n), .irq_oe_n(irq_oe_n));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("Mismatches %0d, comparisons %0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
		int k;
		k = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && k < 50)
		begin
			@(posedge clk);
			k++;
		end
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("pready", 32'(pready), 32'h0000_0001);
	endtask
	task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
		apb(1'b1, idx, wd);
	endtask
	task automatic rd(input string nm, input logic [7:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0000_0000);
		chk(nm, rdata, exp);
	endtask
	// Returns at the edge that samples the strobe high; n counts the wait.
	task automatic stb();
		n = 0;
		@(posedge clk);
		while (sample_strobe !== 1'b1 && n < 2000)
		begin
			@(posedge clk);
			n++;
		end
		chk("strobe_seen", 32'(sample_strobe), 32'h0000_0001);
	endtask
	task automatic move();
		stb();
		repeat (6) @(posedge clk);
	endtask
	task automatic quiet();
		int c;
		c = 0;
		repeat (100)
		begin
			@(posedge clk);
			if (sample_strobe === 1'b1)
				c++;
		end
		chk("no_strobe", 32'(c), 32'h0000_0000);
	endtask
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			err_count++;
			conclude();
		end
	end
	initial
	begin
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		rd("por_state", accel_pkg::dev_status_idx, 32'h0000_0000);
		quiet();
		wr(accel_pkg::range_idx, 32'h0000_0004);
		rd("range_sb", accel_pkg::range_idx, 32'h0000_0004);
		chk("range_pin", 32'(range_select), 32'h0000_0004);
		wr(accel_pkg::soft_reset_idx, 32'h0000_0001);
		rd("reset_refused", accel_pkg::range_idx, 32'h0000_0004);
		wr(accel_pkg::int_enable_idx, 32'h0000_0080);
		wr(accel_pkg::sample_rate_idx, 32'h0000_0004);
		raw <= '{x: 18'h1_FFFF, y: 18'h2_0000, z: 18'h0_0123};
		wr(accel_pkg::mode_idx, 32'h0000_00C1);
		rd("wake_state", accel_pkg::dev_status_idx, 32'h0000_0001);
		move();
		chk("wake_time", 32'(n < 45), 32'h0000_0001);
		chk("pin_high", 32'(irq_out_n), 32'h0000_0001);
		chk("pin_drive", 32'(irq_oe_n), 32'h0000_0000);
		rd("x_lo", accel_pkg::x_lo_idx, 32'h0000_00FF);
		rd("x_hi", accel_pkg::x_hi_idx, 32'h0000_007F);
		rd("y_hi", accel_pkg::y_hi_idx, 32'h0000_0080);
		rd("y_lo", accel_pkg::y_lo_idx, 32'h0000_0000);
		rd("z_lo", accel_pkg::z_lo_idx, 32'h0000_0023);
		stb();
		stb();
		chk("period", 32'(n + 1), 32'(slow >> 4));
		rd("flag_set", accel_pkg::int_status_idx, 32'h0000_0080);
		repeat (4) @(posedge clk);
		chk("pin_clear", 32'(irq_out_n), 32'h0000_0000);
		rd("flag_clear", accel_pkg::int_status_idx, 32'h0000_0000);
		raw <= '{x: 18'h0_0456, y: 18'h0_0000, z: 18'h0_0000};
		stb();
		stb();
		rd("x_held", accel_pkg::x_lo_idx, 32'h0000_00FF);
		i_i2c_master_model.start_cond();
		stb();
		i_i2c_master_model.stop_cond();
		raw <= '{x: 18'h0_0789, y: 18'h0_0000, z: 18'h0_0000};
		// The move lands a few cycles after the STOP has passed the synchroniser.
		repeat (8) @(posedge clk);
		rd("x_moved", accel_pkg::x_lo_idx, 32'h0000_0056);
		i_i2c_master_model.start_cond();
		move();
		rd("x_deferred", accel_pkg::x_lo_idx, 32'h0000_0056);
		i_i2c_master_model.stop_cond();
		move();
		rd("x_new_lo", accel_pkg::x_lo_idx, 32'h0000_0089);
		rd("x_new_hi", accel_pkg::x_hi_idx, 32'h0000_0007);
		wr(accel_pkg::range_idx, 32'h0000_0002);
		rd("range_locked", accel_pkg::range_idx, 32'h0000_0004);
		wr(accel_pkg::mode_idx, 32'h0000_0009);
		wr(accel_pkg::range_idx, 32'h0000_0002);
		rd("range_unlock", accel_pkg::range_idx, 32'h0000_0002);
		chk("od_assert", 32'({irq_out_n, irq_oe_n}), 32'h0000_0000);
		rd("flag_od", accel_pkg::int_status_idx, 32'h0000_0080);
		repeat (4) @(posedge clk);
		chk("od_release", 32'(irq_oe_n), 32'h0000_0001);
		wr(accel_pkg::int_enable_idx, 32'h0000_0000);
		i_i2c_master_model.frame();
		move();
		chk("masked_pin", 32'(irq_oe_n), 32'h0000_0001);
		rd("masked_flag", accel_pkg::int_status_idx, 32'h0000_0080);
		wr(accel_pkg::int_enable_idx, 32'h0000_0080);
		i_i2c_master_model.frame();
		move();
		rd("still_wake", accel_pkg::dev_status_idx, 32'h0000_0001);
		wr(accel_pkg::mode_idx, 32'h0000_000A);
		rd("code10_kept", accel_pkg::dev_status_idx, 32'h0000_0001);
		wr(accel_pkg::mode_idx, 32'h0000_0000);
		rd("standby", accel_pkg::dev_status_idx, 32'h0000_0000);
		rd("flag_kept", accel_pkg::int_status_idx, 32'h0000_0080);
		rd("flag_kept2", accel_pkg::int_status_idx, 32'h0000_0080);
		quiet();
		wr(accel_pkg::mode_idx, 32'h0000_0001);
		wr(accel_pkg::soft_reset_idx, 32'h0000_0001);
		rd("reset_state", accel_pkg::dev_status_idx, 32'h0000_0000);
		rd("reset_range", accel_pkg::range_idx, 32'h0000_0000);
		rd("reset_sample", accel_pkg::x_lo_idx, 32'h0000_0000);
		rd("unmapped", 8'h01, 32'h0000_0000);
		chk("unmapped_err", 32'(rerr), 32'h0000_0001);
		conclude();
	end
endmodule // tb_accel_state_sampling_irq
